// [hdl/sdi_tx_serdes_port.sv]
`timescale 1ns/10ps
`default_nettype none
module sdi_tx_serdes_port #(
  parameter int unsigned          SD_WIDTH = sdi_tx_pkg::SD_10B,
  parameter sdi_tx_pkg::ins_mode_t LN_MODE  = sdi_tx_pkg::INS_OFF,
  parameter sdi_tx_pkg::ins_mode_t CRC_MODE = sdi_tx_pkg::INS_OFF
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // transmit video from user logic
  input  wire logic [19:0] par_video_in,
  input  wire logic        tx_hd_mode,
  input  wire logic        trs_start,
  input  wire logic        crc_insert_en,
  input  wire logic        ln_insert_en,
  input  wire logic [10:0] raw_line_number,
  input  wire logic        line_number_load,
  output logic             par_video_take,
  // serdes transmit channel
  output logic [19:0]      serdes_tx_word,
  output logic             serdes_tx_if_clock,
  // serdes receive channel
  input  wire logic [19:0] serdes_rx_word,
  output logic             serdes_rx_if_clock,
  output logic             elastic_buffer_read_clock,
  output logic [19:0]      rx_par_word,
  // rate request and quad reset
  input  wire logic        rx_want_hd,
  output logic             rx_rate_clock_request,
  output logic             serdes_quad_reset
);

  // ==================================================
  // transmit word pacing
  // a word is taken every second edge so the interface clock can
  // run at half rate with data stable around its rising edge
  logic take_r;
  logic tx_clk_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      take_r   <= 1'b1;
      tx_clk_r <= 1'b0;
    end else begin
      take_r   <= ~take_r;
      tx_clk_r <= ~take_r;
    end
  end

  // ==================================================
  // input conditioning
  wire [7:0] sd8      = par_video_in[9:2];
  wire [1:0] sd8_fill = (sd8 == sdi_tx_pkg::SD8_ONES) ? sdi_tx_pkg::FILL_ONES
                                                      : sdi_tx_pkg::FILL_ZERO;
  wire [9:0] sd_word  = (SD_WIDTH == sdi_tx_pkg::SD_8B) ? {sd8, sd8_fill} : par_video_in[9:0];

  wire sdi_tx_pkg::hd_word_t in_word = tx_hd_mode ? sdi_tx_pkg::hd_word_t'(par_video_in)
                                                  : sdi_tx_pkg::hd_word_t'({10'h000, sd_word});

  // timing start matters only when something is inserted
  wire ins_any  = (LN_MODE != sdi_tx_pkg::INS_OFF) || (CRC_MODE != sdi_tx_pkg::INS_OFF);
  wire trs_used = tx_hd_mode && ins_any;

  // ==================================================
  // stage a: taken word and its place in the reference sequence
  sdi_tx_pkg::hd_word_t a_word_r;
  logic [3:0]           a_pos_r;
  logic                 a_hd_r;
  logic                 a_ln_en_r;
  logic                 a_crc_en_r;

  wire [3:0] pos_nxt = (trs_start && trs_used) ? sdi_tx_pkg::POS_SOT
                     : (a_pos_r == sdi_tx_pkg::POS_IDLE) ? sdi_tx_pkg::POS_IDLE
                     : 4'(a_pos_r + 4'h1);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      a_word_r   <= sdi_tx_pkg::hd_word_t'(sdi_tx_pkg::WORD_RST);
      a_pos_r    <= sdi_tx_pkg::POS_IDLE;
      a_hd_r     <= 1'b0;
      a_ln_en_r  <= 1'b0;
      a_crc_en_r <= 1'b0;
    end else if (take_r) begin
      a_word_r   <= in_word;
      a_pos_r    <= pos_nxt;
      a_hd_r     <= tx_hd_mode;
      a_ln_en_r  <= ln_insert_en;
      a_crc_en_r <= crc_insert_en;
    end
  end

  // ==================================================
  // line number hold and snapshot
  logic [10:0] ln_hold_r;
  logic [10:0] ln_snap_r;
  logic        ln_go_r;
  logic        crc_line_r;

  wire a_is_xyz = (a_pos_r == sdi_tx_pkg::POS_XYZ);
  wire a_eav    = a_word_r.y[sdi_tx_pkg::H_BIT];
  wire ln_allow = (LN_MODE == sdi_tx_pkg::INS_ON) ||
                  ((LN_MODE == sdi_tx_pkg::INS_DYN) && a_ln_en_r);
  wire crc_allow = (CRC_MODE == sdi_tx_pkg::INS_ON) ||
                   ((CRC_MODE == sdi_tx_pkg::INS_DYN) && a_crc_en_r);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ln_hold_r <= sdi_tx_pkg::LN_RESET;
    end else if (line_number_load) begin
      ln_hold_r <= raw_line_number;
    end
  end

  // decisions are made while the xyz word sits in stage a
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ln_snap_r  <= sdi_tx_pkg::LN_RESET;
      ln_go_r    <= 1'b0;
      crc_line_r <= 1'b0;
    end else if (take_r && a_is_xyz) begin
      ln_snap_r  <= ln_hold_r;
      ln_go_r    <= a_hd_r && a_eav && ln_allow;
      crc_line_r <= a_hd_r && a_eav;
    end
  end

  // ==================================================
  // insertion mux
  logic [1:0][17:0] crc;

  wire at_ln   = (a_pos_r == sdi_tx_pkg::POS_LN0) || (a_pos_r == sdi_tx_pkg::POS_LN1);
  wire at_cr   = (a_pos_r == sdi_tx_pkg::POS_CR0) || (a_pos_r == sdi_tx_pkg::POS_CR1);
  wire ln_slot = ln_go_r && at_ln;
  wire crc_slot = crc_line_r && crc_allow && at_cr;

  wire [9:0] ln0_w = sdi_tx_pkg::mark_word({ln_snap_r[6:0], 2'b00});
  wire [9:0] ln1_w = sdi_tx_pkg::mark_word({3'b000, ln_snap_r[10:7], 2'b00});
  wire [9:0] ln_w  = (a_pos_r == sdi_tx_pkg::POS_LN0) ? ln0_w : ln1_w;

  wire       first_cr = (a_pos_r == sdi_tx_pkg::POS_CR0);
  wire [9:0] cr_y = first_cr ? sdi_tx_pkg::mark_word(crc[0][8:0])
                             : sdi_tx_pkg::mark_word(crc[0][17:9]);
  wire [9:0] cr_c = first_cr ? sdi_tx_pkg::mark_word(crc[1][8:0])
                             : sdi_tx_pkg::mark_word(crc[1][17:9]);

  wire sdi_tx_pkg::hd_word_t tx_nxt = ln_slot  ? sdi_tx_pkg::hd_word_t'({ln_w, ln_w})
                                    : crc_slot ? sdi_tx_pkg::hd_word_t'({cr_y, cr_c})
                                    : a_word_r;

  // crc covers words after sav through the second line number word, except the third and fourth words after sav
  wire crc_clear  = take_r && a_is_xyz && !a_eav && a_hd_r;
  wire crc_update = take_r && !at_cr;

  sdi_crc_pair u_crc (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clear  (crc_clear),
    .update (crc_update),
    .word   (tx_nxt),
    .crc    (crc)
  );

  // ==================================================
  // transmit word register
  sdi_tx_pkg::hd_word_t tx_word_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_word_r <= sdi_tx_pkg::hd_word_t'(sdi_tx_pkg::WORD_RST);
    end else if (take_r) begin
      tx_word_r <= tx_nxt;
    end
  end

  // ==================================================
  // receive side, kept apart from transmit
  logic [19:0] rx_s1_r;
  logic [19:0] rx_s2_r;
  logic [19:0] rx_word_r;
  logic        rx_clk_r;
  logic        rate_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_r   <= sdi_tx_pkg::WORD_RST;
      rx_s2_r   <= sdi_tx_pkg::WORD_RST;
      rx_word_r <= sdi_tx_pkg::WORD_RST;
      rx_clk_r  <= 1'b0;
      rate_r    <= 1'b0;
    end else begin
      rx_s1_r   <= serdes_rx_word;
      rx_s2_r   <= rx_s1_r;
      rx_word_r <= rx_s2_r;
      rx_clk_r  <= ~rx_clk_r;
      rate_r    <= rx_want_hd;
    end
  end

  // ==================================================
  // quad reset, stretched past the core reset release
  logic [3:0] qr_cnt_r;
  logic       quad_rst_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      qr_cnt_r   <= 4'h0;
      quad_rst_r <= 1'b1;
    end else if (qr_cnt_r != sdi_tx_pkg::QUAD_RST_CNT) begin
      qr_cnt_r   <= 4'(qr_cnt_r + 4'h1);
      quad_rst_r <= 4'(qr_cnt_r + 4'h1) != sdi_tx_pkg::QUAD_RST_CNT;
    end
  end

  // ==================================================
  // outputs
  assign par_video_take            = take_r;
  assign serdes_tx_word            = tx_word_r;
  assign serdes_tx_if_clock        = tx_clk_r;
  assign serdes_rx_if_clock        = rx_clk_r;
  assign elastic_buffer_read_clock = rx_clk_r;
  assign rx_par_word               = rx_word_r;
  assign rx_rate_clock_request     = rate_r;
  assign serdes_quad_reset         = quad_rst_r;

  // ==================================================
  // checks
  property p_ln_hold;
    @(posedge mclk) disable iff (!rst_n)
    line_number_load |=> ln_hold_r == $past(raw_line_number);
  endproperty
  a_ln_hold: assert property (p_ln_hold) else $error("line number not held");

  property p_ln_word;
    @(posedge mclk) disable iff (!rst_n)
    take_r && ln_go_r && a_pos_r == sdi_tx_pkg::POS_LN0
      |=> tx_word_r.y[8:2] == ln_snap_r[6:0] && tx_word_r.y[9] != tx_word_r.y[8];
  endproperty
  a_ln_word: assert property (p_ln_word) else $error("first line number word wrong");

  property p_ln_dyn;
    @(posedge mclk) disable iff (!rst_n)
    LN_MODE == sdi_tx_pkg::INS_DYN && take_r && a_is_xyz && !a_ln_en_r |=> !ln_go_r;
  endproperty
  a_ln_dyn: assert property (p_ln_dyn) else $error("line number inserted without enable");

  property p_pass;
    @(posedge mclk) disable iff (!rst_n)
    take_r && !ln_slot && !crc_slot |=> tx_word_r == $past(a_word_r);
  endproperty
  a_pass: assert property (p_pass) else $error("word altered on pass through");

  property p_crc0;
    @(posedge mclk) disable iff (!rst_n)
    take_r && crc_slot && first_cr ##1 1 ##1 take_r
      |-> tx_word_r.c[8:0] == $past(crc[1][8:0], 2);
  endproperty
  a_crc0: assert property (p_crc0) else $error("crc word wrong");

  property p_crc_dyn;
    @(posedge mclk) disable iff (!rst_n)
    CRC_MODE == sdi_tx_pkg::INS_DYN && take_r && at_cr && !a_crc_en_r |=> tx_word_r == $past(a_word_r);
  endproperty
  a_crc_dyn: assert property (p_crc_dyn) else $error("crc inserted without enable");

  property p_trs_ignored;
    @(posedge mclk) disable iff (!rst_n)
    take_r && !trs_used && a_pos_r == sdi_tx_pkg::POS_IDLE |=> a_pos_r == sdi_tx_pkg::POS_IDLE;
  endproperty
  a_trs_ignored: assert property (p_trs_ignored) else $error("timing start not ignored");

  property p_sd8;
    @(posedge mclk) disable iff (!rst_n)
    SD_WIDTH == sdi_tx_pkg::SD_8B && take_r && !tx_hd_mode
      |=> a_word_r.c == {$past(par_video_in[9:2]), {2{&$past(par_video_in[9:2])}}};
  endproperty
  a_sd8: assert property (p_sd8) else $error("8-bit sd word wrong");

  property p_tx_stable;
    @(posedge mclk) disable iff (!rst_n)
    $changed(tx_word_r) |-> !tx_clk_r ##1 tx_clk_r && $stable(tx_word_r);
  endproperty
  a_tx_stable: assert property (p_tx_stable) else $error("tx word not stable at clock rise");

  property p_rx_word;
    @(posedge mclk) disable iff (!rst_n)
    1 ##3 1 |-> rx_word_r == $past(serdes_rx_word, 3);
  endproperty
  a_rx_word: assert property (p_rx_word) else $error("receive word lost");

  property p_quad;
    @(posedge mclk) disable iff (!rst_n)
    quad_rst_r |-> ##[1:5] !quad_rst_r;
  endproperty
  a_quad: assert property (p_quad) else $error("quad reset stuck");

  property p_rate;
    @(posedge mclk) disable iff (!rst_n)
    rx_want_hd ##1 rx_want_hd |-> rate_r;
  endproperty
  a_rate: assert property (p_rate) else $error("rate request wrong");

endmodule : sdi_tx_serdes_port
`default_nettype wire

// [include/sdi_tx_pkg.sv]
`default_nettype none
package sdi_tx_pkg;

  // ==================================================
  // words and modes
  typedef struct packed {
    logic [9:0] y;
    logic [9:0] c;
  } hd_word_t;

  typedef enum logic [1:0] {INS_OFF, INS_ON, INS_DYN} ins_mode_t;

  localparam int unsigned LN_W    = 11;
  localparam int unsigned CRC_W   = 18;
  localparam int unsigned H_BIT   = 6;
  localparam int unsigned SD_8B   = 8;
  localparam int unsigned SD_10B  = 10;

  // ==================================================
  // positions after the timing reference start word
  localparam logic [3:0] POS_SOT  = 4'h0;
  localparam logic [3:0] POS_XYZ  = 4'h3;
  localparam logic [3:0] POS_LN0  = 4'h4;
  localparam logic [3:0] POS_LN1  = 4'h5;
  localparam logic [3:0] POS_CR0  = 4'h6;
  localparam logic [3:0] POS_CR1  = 4'h7;
  localparam logic [3:0] POS_IDLE = 4'h8;

  // ==================================================
  // fill, crc and reset values
  localparam logic [7:0]  SD8_ONES  = 8'hFF;
  localparam logic [1:0]  FILL_ONES = 2'h3;
  localparam logic [1:0]  FILL_ZERO = 2'h0;
  localparam logic [17:0] CRC_POLY  = 18'h23000;
  localparam logic [17:0] CRC_INIT  = 18'h00000;
  localparam logic [10:0] LN_RESET  = 11'h000;
  localparam logic [19:0] WORD_RST  = 20'h00000;

  // ==================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned QUAD_RST_NS   = 50;
  localparam int unsigned QUAD_RST_CYC  = (QUAD_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  QUAD_RST_CNT  = 4'(QUAD_RST_CYC);

  // 9 payload bits with bit 9 as the inverse of bit 8
  function automatic logic [9:0] mark_word(input logic [8:0] b);
    return {~b[8], b};
  endfunction : mark_word

endpackage : sdi_tx_pkg
`default_nettype wire

// [hdl/sdi_crc_pair.sv]
`timescale 1ns/10ps
`default_nettype none
module sdi_crc_pair (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // control
  input  wire logic                 clear,
  input  wire logic                 update,
  // data
  input  wire sdi_tx_pkg::hd_word_t word,
  output logic [1:0][17:0]          crc
);

  // ==================================================
  // one 10-bit word per update, lsb first
  function automatic logic [17:0] crc_step(input logic [17:0] cur, input logic [9:0] d);
    logic [17:0] c;
    logic        fb;
    c = cur;
    for (int i = 0; i < 10; i++) begin
      fb = c[0] ^ d[i];
      c  = {1'b0, c[17:1]};
      if (fb) begin
        c = c ^ sdi_tx_pkg::CRC_POLY;
      end
    end
    return c;
  endfunction : crc_step

  // ==================================================
  // luma is channel 0, chroma channel 1
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic [17:0] crc_r;
      wire  [9:0]  din = (ch == 0) ? word.y : word.c;
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          crc_r <= sdi_tx_pkg::CRC_INIT;
        end else if (clear) begin
          crc_r <= sdi_tx_pkg::CRC_INIT;
        end else if (update) begin
          crc_r <= crc_step(crc_r, din);
        end
      end
      assign crc[ch] = crc_r;
    end
  endgenerate

endmodule : sdi_crc_pair
`default_nettype wire

// [bench/serdes_partner.sv]
`timescale 1ns/10ps
`default_nettype none
module serdes_partner (
  // transmit lane from the port
  input  wire logic [19:0] serdes_tx_word,
  input  wire logic        serdes_tx_if_clock,
  // receive lane towards the port
  input  wire logic        elastic_buffer_read_clock,
  input  wire logic        serdes_quad_reset,
  output logic [19:0]      serdes_rx_word
);
  logic [19:0] tx_q[$];

  // ==================================================
  // transmit capture
  // words are only trusted at the rising interface clock, mid-way through their two cycles
  always @(posedge serdes_tx_if_clock) tx_q.push_back(serdes_tx_word);

  // ==================================================
  // receive drain
  initial serdes_rx_word = 20'h00000;
  // a quad held in reset gives no data: flip the lane so stale words never look valid
  always @(posedge elastic_buffer_read_clock) begin
    if (serdes_quad_reset) serdes_rx_word <= #1 ~serdes_rx_word;
    else serdes_rx_word <= #1 serdes_rx_word + 20'h0A5C3;
  end
endmodule : serdes_partner
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [2:0]  ctl;
    logic [19:0] din;
    logic [19:0] dout;
  } row_t;
  localparam logic [19:0] IDLE = 20'h10040;
  logic        mclk, rst_n, tx_hd_mode, trs_start, crc_insert_en, ln_insert_en;
  logic        line_number_load, rx_want_hd, par_video_take, serdes_tx_if_clock;
  logic        serdes_rx_if_clock, elastic_buffer_read_clock, rx_rate_clock_request, serdes_quad_reset;
  logic        clk_prev, want_prev;
  logic [10:0] raw_line_number;
  logic [19:0] par_video_in, serdes_rx_word, serdes_tx_word, rx_par_word, tx_prev;
  logic [19:0] rx_h[3];
  logic [19:0] exp_q[$];
  int          err_count, n_checks, rx_ok, cyc;
  // ctl: hd, timing start, line number enable
  row_t        rows[26] = '{
    '{3'h6, 20'hFFFFF, 20'hFFFFF}, '{3'h4, 20'h00000, 20'h00000}, '{3'h4, 20'h00000, 20'h00000},
    '{3'h5, 20'h9D274, 20'h9D274}, '{3'h4, 20'h12345, 20'hA328C}, '{3'h4, 20'h12345, 20'h8B22C},
    '{3'h4, 20'h2A1B5, 20'h2A1B5}, '{3'h4, 20'h3C0F7, 20'h3C0F7}, '{3'h4, 20'h10040, 20'h10040},
    '{3'h6, 20'hFFFFF, 20'hFFFFF}, '{3'h4, 20'h00000, 20'h00000}, '{3'h4, 20'h00000, 20'h00000},
    '{3'h4, 20'h9D274, 20'h9D274}, '{3'h5, 20'h12345, 20'h12345}, '{3'h4, 20'h54321, 20'h54321},
    '{3'h3, 20'hFFFFF, 20'h003FF}, '{3'h1, 20'h00000, 20'h00000}, '{3'h1, 20'h00000, 20'h00000},
    '{3'h1, 20'h9D274, 20'h00274}, '{3'h1, 20'h12345, 20'h00345},
    '{3'h6, 20'hFFFFF, 20'hFFFFF}, '{3'h4, 20'h00000, 20'h00000}, '{3'h4, 20'h00000, 20'h00000},
    '{3'h5, 20'h9D274, 20'h9D274}, '{3'h4, 20'h12345, 20'h80200}, '{3'h4, 20'h12345, 20'h80200}};

  sdi_tx_serdes_port #(
    .SD_WIDTH (sdi_tx_pkg::SD_10B),
    .LN_MODE  (sdi_tx_pkg::INS_DYN),
    .CRC_MODE (sdi_tx_pkg::INS_DYN)
  ) uut (
    .mclk                      (mclk),
    .rst_n                     (rst_n),
    .par_video_in              (par_video_in),
    .tx_hd_mode                (tx_hd_mode),
    .trs_start                 (trs_start),
    .crc_insert_en             (crc_insert_en),
    .ln_insert_en              (ln_insert_en),
    .raw_line_number           (raw_line_number),
    .line_number_load          (line_number_load),
    .par_video_take            (par_video_take),
    .serdes_tx_word            (serdes_tx_word),
    .serdes_tx_if_clock        (serdes_tx_if_clock),
    .serdes_rx_word            (serdes_rx_word),
    .serdes_rx_if_clock        (serdes_rx_if_clock),
    .elastic_buffer_read_clock (elastic_buffer_read_clock),
    .rx_par_word               (rx_par_word),
    .rx_want_hd                (rx_want_hd),
    .rx_rate_clock_request     (rx_rate_clock_request),
    .serdes_quad_reset         (serdes_quad_reset)
  );

  serdes_partner u_serdes (
    .serdes_tx_word            (serdes_tx_word),
    .serdes_tx_if_clock        (serdes_tx_if_clock),
    .elastic_buffer_read_clock (elastic_buffer_read_clock),
    .serdes_quad_reset         (serdes_quad_reset),
    .serdes_rx_word            (serdes_rx_word)
  );

  // ==================================================
  // helpers
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task automatic send(input row_t r);
    int i;
    i = 0;
    while (par_video_take !== 1'b1 && i < 8) begin
      @(negedge mclk);
      i++;
    end
    if (i == 8) begin
      err_count++;
      finish_test();
    end
    {tx_hd_mode, trs_start, ln_insert_en} = r.ctl;
    par_video_in = r.din;
    exp_q.push_back(r.dout);
    @(negedge mclk);
  endtask : send

  task automatic run_rows(input int lo, input int hi);
    int k;
    u_serdes.tx_q.delete();
    exp_q.delete();
    for (k = lo; k < hi; k++) send(rows[k]);
    {tx_hd_mode, trs_start, ln_insert_en} = 3'h4;
    par_video_in = IDLE;
    repeat (8) @(negedge mclk);
    // the lane carries idle and reset words before the stream; skip to its first word
    while (u_serdes.tx_q.size() > 0 && u_serdes.tx_q[0] !== exp_q[0]) void'(u_serdes.tx_q.pop_front());
    foreach (exp_q[j]) begin
      if (u_serdes.tx_q.size() > 0) chk(u_serdes.tx_q.pop_front(), exp_q[j]);
      else chk(20'hXXXXX, exp_q[j]);
    end
  endtask : run_rows

  task automatic release_chk();
    int k;
    rst_n = 1'b1;
    for (k = 1; k <= 5; k++) begin
      @(negedge mclk);
      chk({19'h0, serdes_quad_reset}, {19'h0, k < 5});
    end
  endtask : release_chk

  // ==================================================
  // clock, receive history and free-running monitors
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rx_ok <= 0;
    else if (rx_ok < 3) rx_ok <= rx_ok + 1;
  end

  always @(posedge mclk) begin
    rx_h[2] <= rx_h[1];
    rx_h[1] <= rx_h[0];
    rx_h[0] <= serdes_rx_word;
  end

  // receive runs alongside every transmit scenario, so independence is exercised throughout
  // skip the edge on which reset is applied, before the counter has seen it
  always @(negedge mclk) begin
    if (rx_ok >= 3 && rst_n === 1'b1) begin
      chk(rx_par_word, rx_h[2]);
      chk({19'h0, elastic_buffer_read_clock}, {19'h0, serdes_rx_if_clock});
      chk({19'h0, serdes_rx_if_clock}, {19'h0, ~clk_prev});
      chk({19'h0, rx_rate_clock_request}, {19'h0, want_prev});
      if (serdes_tx_if_clock === 1'b1) chk(serdes_tx_word, tx_prev);
    end
    clk_prev = serdes_rx_if_clock;
    tx_prev = serdes_tx_word;
    cyc++;
    rx_want_hd = cyc[1] ^ cyc[3];
    want_prev = rx_want_hd;
  end

  // ==================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    {tx_hd_mode, trs_start, ln_insert_en} = 3'h4;
    // dynamic crc left disabled: the stream carries its own check words
    crc_insert_en = 1'b0;
    par_video_in = IDLE;
    raw_line_number = 11'h000;
    line_number_load = 1'b0;
    rx_want_hd = 1'b0;
    cyc = 0;
    err_count = 0;
    n_checks = 0;
    repeat (4) @(negedge mclk);
    release_chk();
    raw_line_number = 11'h5A3;
    line_number_load = 1'b1;
    @(negedge mclk);
    // changed without a load: the held value must still be the one inserted
    line_number_load = 1'b0;
    raw_line_number = 11'h7FF;
    run_rows(0, 20);
    rst_n = 1'b0;
    @(negedge mclk);
    chk(serdes_tx_word, 20'h00000);
    chk({18'h0, par_video_take, serdes_quad_reset}, 20'h00003);
    chk({19'h0, rx_rate_clock_request}, 20'h00000);
    release_chk();
    run_rows(20, 26);
    finish_test();
  end
endmodule : tb
`default_nettype wire
